// ---- rtl/_unused_marker_none.v ----
/*
  intentionally empty; holds no logic.
  assumes nothing.
*/

// ---- rtl/baud_gen.v ----
/*
  baud rate generator: source selection, clock divisor with optional
  fractional extension, oversampling divide, smart-card second divider and
  serial clock pin drive, with an apb register slave.
  assumes all inputs synchronous to core_clk and sck_in well below core_clk.
*/
// Design decisions made here: the APB interface to the registers and the address map.
// Operation
// - async: source divided by divisor gives sample clock, then by 16 or 8.
// - oversampling select 1 gives 8 samples per bit, 0 gives 16.
// - nonzero fraction extends divisor by fraction over eight.
// - fraction applies only in plain serial mode, never in special modes.
// - sync: bit clock is source divided by divisor, no oversampling.
// - sync with external source: serial clock pin is bit clock, divisor ignored.
// - master clock source gives 50:50 pin duty for even divisors and divisor 1; odd divisors above 1 stay high one cycle longer.
// - smart-card: divisor output is card clock, driven on pin when enabled.
// - smart-card: card clock divided by ratio field, up to 2047.
// - ratio field resets to 0x174.
// - rate adjust code maps to 1,2,4,8,16,32,12,20.
// - clock division code maps to 372..2048 per table.
// - divisor 0 stops the clock except in sync with external source, divisor 1 bypasses the divider.
// - source is master clock, master clock over 8, or serial clock pin.
`include "baud_gen_regs.vh"

module baud_gen (
  input  wire        core_clk,
  input  wire        reset_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        sck_in,
  output reg         sck_out,
  output reg         sck_oe,
  output reg         sample_tick,
  output reg         baud_tick
);

  function [11:0] fi_decode;
    input [3:0] code;
    begin
      case (code)
        4'h0, 4'h1: fi_decode = 12'd372;
        4'h2:       fi_decode = 12'd558;
        4'h3:       fi_decode = 12'd744;
        4'h4:       fi_decode = 12'd1116;
        4'h5:       fi_decode = 12'd1488;
        4'h6:       fi_decode = 12'd1860;
        4'h9:       fi_decode = 12'd512;
        4'ha:       fi_decode = 12'd768;
        4'hb:       fi_decode = 12'd1024;
        4'hc:       fi_decode = 12'd1536;
        4'hd:       fi_decode = 12'd2048;
        default:    fi_decode = 12'd0;
      endcase
    end
  endfunction

  function [5:0] di_decode;
    input [3:0] code;
    begin
      case (code)
        4'h1:    di_decode = 6'd1;
        4'h2:    di_decode = 6'd2;
        4'h3:    di_decode = 6'd4;
        4'h4:    di_decode = 6'd8;
        4'h5:    di_decode = 6'd16;
        4'h6:    di_decode = 6'd32;
        4'h8:    di_decode = 6'd12;
        4'h9:    di_decode = 6'd20;
        default: di_decode = 6'd0;
      endcase
    end
  endfunction

  reg  [31:0] mode_register_q;
  reg  [31:0] baud_gen_register_q;
  reg  [10:0] iso_sampling_divider_q;
  reg  [7:0]  iso_code_q;
  reg         sck_prev_q;
  reg  [3:0]  pre_q;
  reg  [15:0] div_cnt_q;
  reg  [2:0]  frac_acc_q;
  reg  [4:0]  over_cnt_q;
  reg  [10:0] iso_cnt_q;
  // divisor 1: the pin toggles on each source step since no divider runs
  reg         core_clk_half_q;
  reg         sck_div1_q;

  wire [3:0]  op_mode              = mode_register_q[`MODE_OP_MSB:`MODE_OP_LSB];
  wire [1:0]  baud_source_select   = mode_register_q[`MODE_SRC_MSB:`MODE_SRC_LSB];
  wire        sync_mode            = mode_register_q[`MODE_SYNC_BIT];
  wire        card_clock_output    = mode_register_q[`MODE_CLKOUT_BIT];
  wire        over                 = mode_register_q[`MODE_OVER_BIT];
  wire [15:0] clock_divisor        = baud_gen_register_q[`BG_CD_MSB:`BG_CD_LSB];
  wire [2:0]  fraction_part        = baud_gen_register_q[`BG_FP_MSB:`BG_FP_LSB];
  wire [3:0]  rate_adjust_code     = iso_code_q[3:0];
  wire [3:0]  clock_division_code  = iso_code_q[7:4];

  wire iso_mode = (op_mode == `OP_ISO_T0) || (op_mode == `OP_ISO_T1);
  wire ext_direct = sync_mode && (baud_source_select == `SRC_EXT);

  // source clock enable per selected source
  wire sck_rise = sck_in && !sck_prev_q;
  reg  src_en;
  always @* begin
    case (baud_source_select)
      `SRC_MCK:     src_en = 1'b1;
      `SRC_MCK_DIV: src_en = (pre_q == `MCK_DIV_FACTOR - 4'h1);
      `SRC_EXT:     src_en = sck_rise;
      default:      src_en = 1'b0;
    endcase
  end

  // fractional carry lengthens this period by one source clock
  wire        frac_on   = (fraction_part != 3'h0) && !sync_mode
                          && (op_mode == `OP_NORMAL);
  wire [3:0]  frac_sum  = {1'b0, frac_acc_q} + {1'b0, fraction_part};
  wire        frac_ext  = frac_on && frac_sum[3];
  wire [16:0] limit     = {1'b0, clock_divisor} + {16'h0, frac_ext};
  wire        cd_zero   = (clock_divisor == 16'h0);
  wire        div_tc    = ({1'b0, div_cnt_q} >= limit - 17'h1);
  // divisor 1 gives tc every enable, so the divider is bypassed
  wire        div_pulse = src_en && div_tc && !cd_zero;
  wire [16:0] half      = (limit + 17'h1) >> 1;

  wire [4:0]  over_lim  = over ? `OVERSAMPLE_8 : `OVERSAMPLE_16;
  // >= so a limit lowered mid-count ends the period at once instead of wrapping
  wire        over_tc   = (over_cnt_q >= over_lim - 5'h1);
  wire        iso_zero  = (iso_sampling_divider_q == 11'h0);
  wire        iso_tc    = (iso_cnt_q >= iso_sampling_divider_q - 11'h1);

  reg         sample_d;
  reg         baud_d;
  always @* begin
    sample_d = 1'b0;
    baud_d   = 1'b0;
    if (iso_mode) begin
      baud_d = div_pulse && iso_tc && !iso_zero;
    end else if (sync_mode) begin
      if (ext_direct) begin
        baud_d = sck_rise;
      end else begin
        baud_d = div_pulse;
      end
    end else begin
      sample_d = div_pulse;
      baud_d   = div_pulse && over_tc;
    end
  end

  // pin clock: high for the first half of each divided period
  reg sck_d;
  reg sck_oe_d;
  always @* begin
    sck_d    = !cd_zero && ({1'b0, div_cnt_q} < half);
    sck_oe_d = 1'b0;
    if (iso_mode) begin
      sck_oe_d = card_clock_output;
    end else if (sync_mode && !ext_direct) begin
      sck_oe_d = 1'b1;
    end
    if (clock_divisor == 16'h1) begin
      sck_d = (baud_source_select == `SRC_MCK) ? core_clk_half_q : sck_div1_q;
    end
  end

  // pin edge detect and the toggles used while the divider is bypassed
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_prev_q      <= 1'b0;
      core_clk_half_q <= 1'b0;
      sck_div1_q      <= 1'b0;
    end else begin
      sck_prev_q      <= sck_in;
      core_clk_half_q <= !core_clk_half_q;
      if (src_en) begin
        sck_div1_q <= !sck_div1_q;
      end
    end
  end

  // fixed prescaler behind the divided master clock source
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_q <= 4'h0;
    end else if (pre_q == `MCK_DIV_FACTOR - 4'h1) begin
      pre_q <= 4'h0;
    end else begin
      pre_q <= pre_q + 4'h1;
    end
  end

  // clock divisor with the fractional accumulator
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_q  <= 16'h0;
      frac_acc_q <= 3'h0;
    end else if (cd_zero) begin
      div_cnt_q <= 16'h0;
    end else if (src_en) begin
      if (div_tc) begin
        div_cnt_q  <= 16'h0;
        frac_acc_q <= frac_on ? frac_sum[2:0] : 3'h0;
      end else begin
        div_cnt_q <= div_cnt_q + 16'h1;
      end
    end
  end

  // oversampling counter, one step per divided period
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      over_cnt_q <= 5'h0;
    end else if (div_pulse) begin
      over_cnt_q <= over_tc ? 5'h0 : over_cnt_q + 5'h1;
    end
  end

  // smart-card ratio counter, one step per card clock period
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      iso_cnt_q <= 11'h0;
    end else if (div_pulse) begin
      if (iso_tc || iso_zero) begin
        iso_cnt_q <= 11'h0;
      end else begin
        iso_cnt_q <= iso_cnt_q + 11'h1;
      end
    end
  end

  // registered outputs
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sample_tick <= 1'b0;
      baud_tick   <= 1'b0;
      sck_out     <= 1'b0;
      sck_oe      <= 1'b0;
    end else begin
      sample_tick <= sample_d;
      baud_tick   <= baud_d;
      sck_out     <= sck_d;
      sck_oe      <= sck_oe_d;
    end
  end

  // apb slave: answer prepared in setup, pready high in the access cycle
  wire setup  = psel && !penable;
  wire access = psel && penable && pready;
  reg  [31:0] rd_d;
  reg         hit_d;
  always @* begin
    rd_d  = 32'h0;
    hit_d = 1'b1;
    case (paddr)
      `MODE_REG_ADDR:      rd_d = mode_register_q;
      `BAUD_GEN_REG_ADDR:  rd_d = baud_gen_register_q;
      `ISO_RATIO_REG_ADDR: rd_d = {21'h0, iso_sampling_divider_q};
      `ISO_CODE_REG_ADDR:  rd_d = {24'h0, iso_code_q};
      `ISO_DEC_REG_ADDR:   rd_d = {4'h0, fi_decode(clock_division_code), 10'h0,
                                   di_decode(rate_adjust_code)};
      `STATUS_REG_ADDR:    rd_d = {28'h0, sck_oe, sck_out, frac_acc_q != 3'h0,
                                   div_cnt_q != 16'h0};
      default:             hit_d = 1'b0;
    endcase
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata                 <= 32'h0;
      pready                 <= 1'b0;
      pslverr                <= 1'b0;
      mode_register_q        <= `MODE_RESET;
      baud_gen_register_q    <= `BG_RESET;
      iso_sampling_divider_q <= `ISO_RATIO_RESET;
      iso_code_q             <= `ISO_CODE_RESET;
    end else begin
      pready  <= setup;
      pslverr <= setup && !hit_d;
      prdata  <= (setup && !pwrite) ? rd_d : 32'h0;
      if (access && pwrite) begin
        case (paddr)
          `MODE_REG_ADDR:      mode_register_q <= pwdata;
          `BAUD_GEN_REG_ADDR:  baud_gen_register_q <= {13'h0, pwdata[18:0]};
          `ISO_RATIO_REG_ADDR: iso_sampling_divider_q <= pwdata[10:0];
          `ISO_CODE_REG_ADDR:  iso_code_q <= pwdata[7:0];
          default:             ;
        endcase
      end
    end
  end

endmodule // baud_gen

// ---- rtl/baud_gen_regs.vh ----
/*
  register map, field positions, reset values and fixed counts of the baud generator.
  assumes a 32-bit apb bus with byte addresses on word boundaries.
*/
`ifndef BAUD_GEN_REGS_VH
`define BAUD_GEN_REGS_VH

`define MODE_REG_ADDR      8'h04
`define BAUD_GEN_REG_ADDR  8'h20
`define ISO_RATIO_REG_ADDR 8'h40
`define ISO_CODE_REG_ADDR  8'h44
`define ISO_DEC_REG_ADDR   8'h48
`define STATUS_REG_ADDR    8'h50

// mode register fields
`define MODE_OP_LSB        0
`define MODE_OP_MSB        3
`define MODE_SRC_LSB       4
`define MODE_SRC_MSB       5
`define MODE_SYNC_BIT      8
`define MODE_CLKOUT_BIT    18
`define MODE_OVER_BIT      19
`define MODE_RESET         32'h0000_0000

// operating mode codes: 0 plain serial, iso codes select smart-card
`define OP_NORMAL          4'h0
`define OP_ISO_T0          4'h4
`define OP_ISO_T1          4'h6

// clock source codes
`define SRC_MCK            2'h0
`define SRC_MCK_DIV        2'h1
`define SRC_EXT            2'h3

// baud generator register fields
`define BG_CD_LSB          0
`define BG_CD_MSB          15
`define BG_FP_LSB          16
`define BG_FP_MSB          18
`define BG_RESET           32'h0000_0000

`define ISO_RATIO_RESET    11'h174
`define ISO_CODE_RESET     8'h11

// fixed prescale of the divided master clock, oversampling counts and fraction steps
`define MCK_DIV_FACTOR     4'h8
`define OVERSAMPLE_16      5'h10
`define OVERSAMPLE_8       5'h08
`define FRAC_STEPS         4'h8

`endif

// ---- testbench/baud_gen_props.sv ----
/* assertion checker for the baud generator, bound to its top ports.
   assumes the clock setup changes only through apb writes. */
`include "baud_gen_regs.vh"
module baud_gen_props (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sck_in,
  input wire logic        sck_out,
  input wire logic        sck_oe,
  input wire logic        sample_tick,
  input wire logic        baud_tick
);
  logic [31:0] mode_q;
  logic [31:0] bg_q;
  logic [15:0] gap_q;
  logic [4:0]  sc_q;
  logic        sp_q;
  logic        bp_q;
  wire wr    = psel && penable && pready && pwrite;
  wire async = !mode_q[`MODE_SYNC_BIT] && mode_q[3:0] == `OP_NORMAL;
  wire ext   = mode_q[`MODE_SYNC_BIT] && mode_q[5:4] == `SRC_EXT;
  wire iso   = mode_q[3:0] == `OP_ISO_T0 || mode_q[3:0] == `OP_ISO_T1;
  // shadow copies of the clock setup; periods are trusted only after a tick
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= 32'h0;
      bg_q   <= 32'h0;
      gap_q  <= 16'h0;
      sc_q   <= 5'h0;
      sp_q   <= 1'b0;
      bp_q   <= 1'b0;
    end else begin
      if (wr && paddr == `MODE_REG_ADDR) mode_q <= pwdata;
      if (wr && paddr == `BAUD_GEN_REG_ADDR) bg_q <= pwdata;
      sp_q  <= wr ? 1'b0 : sp_q | sample_tick;
      bp_q  <= wr ? 1'b0 : bp_q | baud_tick;
      gap_q <= sample_tick ? 16'h0 : gap_q + 16'h1;
      sc_q  <= baud_tick ? 5'h0 : sc_q + {4'h0, sample_tick};
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence ext_rise; ext && $rose(sck_in); endsequence
  sequence tick_next; ##1 baud_tick; endsequence
  setup_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error response");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  unmapped_err_a: assert property (psel && !penable && !(paddr inside {`MODE_REG_ADDR,
    `BAUD_GEN_REG_ADDR, `ISO_RATIO_REG_ADDR, `ISO_CODE_REG_ADDR, `ISO_DEC_REG_ADDR,
    `STATUS_REG_ADDR}) |=> pslverr) else $error("unmapped address accepted");
  sample_gap_a: assert property (
    async && mode_q[5:4] == `SRC_MCK && bg_q[18:16] == 3'h0 && sp_q && sample_tick
    |-> gap_q + 16'h1 == bg_q[15:0]) else $error("sample period wrong");
  baud_over_a: assert property (
    async && bp_q && baud_tick |-> sc_q + {4'h0, sample_tick} ==
    (mode_q[`MODE_OVER_BIT] ? `OVERSAMPLE_8 : `OVERSAMPLE_16)) else $error("oversampling wrong");
  no_clock_a: assert property (
    (bg_q[15:0] == 16'h0 && !ext)[*3] |-> !baud_tick && !sample_tick)
    else $error("tick with zero divisor");
  ext_tick_a: assert property (ext_rise |-> tick_next)
    else $error("external edge gave no tick");
  card_oe_a: assert property (
    iso && mode_q[`MODE_CLKOUT_BIT] && mode_q == $past(mode_q) |-> sck_oe)
    else $error("card clock not driven");
endmodule // baud_gen_props

bind baud_gen baud_gen_props baud_gen_props_i (.core_clk(core_clk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_in(sck_in),
  .sck_out(sck_out), .sck_oe(sck_oe), .sample_tick(sample_tick), .baud_tick(baud_tick));

// ---- testbench/serial_clock_source.sv ----
/* remote device driving the serial clock pin.
   assumes the bench releases the pin whenever the block drives it. */
module serial_clock_source (
  input  wire logic run,
  output logic      sck_ext
);
  timeunit 1ns;
  timeprecision 1ps;
  parameter int HALF_NS = 50;
  initial sck_ext = 1'b0;
  // ten core cycles per period, edges on falling core edges, never on a rising one; still outside frames
  always begin
    #(HALF_NS);
    sck_ext = run ? ~sck_ext : 1'b0;
  end
endmodule // serial_clock_source

// ---- testbench/test_usart_baud_rate_generator.sv ----
/* self-checking bench for the baud generator over apb.
   assumes the checker is bound in and the pin is resolved here. */
`include "baud_gen_regs.vh"
module test_usart_baud_rate_generator;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, run = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0;
  wire  [31:0] prdata;
  wire         pready, pslverr, sck_out, sck_oe, sample_tick, baud_tick, sck_ext, sck_in;
  int          fail_count = 0, num_checks = 0, cd, ov;
  logic [32:0] q[$];
  logic [3:0]  dic[8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9};
  int          div[8] = '{1, 2, 4, 8, 16, 32, 12, 20};
  logic [3:0]  fic[12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'ha, 4'hb,
                           4'hc, 4'hd};
  int          fiv[12] = '{372, 372, 558, 744, 1116, 1488, 1860, 512, 768, 1024, 1536, 2048};
  assign sck_in = sck_oe ? sck_out : sck_ext;
  always #5 core_clk = ~core_clk;
  baud_gen baud_gen_i (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sck_in(sck_in), .sck_out(sck_out),
    .sck_oe(sck_oe), .sample_tick(sample_tick), .baud_tick(baud_tick));
  serial_clock_source serial_clock_source_i (.run(run), .sck_ext(sck_ext));
  task check(input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge core_clk);
    if (!w) q.push_back(e);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    @(posedge core_clk iff pready === 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d); apb(1, a, d, 0); endtask
  task rd(input logic [7:0] a, input logic [32:0] e); apb(0, a, 0, e); endtask
  // read results are compared as they appear, against the oldest note
  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) check({pslverr, prdata}, q.pop_front());
  end
  // cycles across n bit periods, skipping everything up to the second tick after a change
  task meas(input int n, input int e);
    int t, k, c;
    c = 0;
    k = 0;
    for (t = 0; t < 3000 && k <= n + 1; t++) begin
      @(negedge core_clk);
      if (k > 1) c++;
      if (baud_tick === 1'b1) k++;
    end
    check(33'(c), 33'(e));
  endtask
  // high cycles of the pin clock over n cycles
  task duty(input int n, input int e);
    int h;
    h = 0;
    repeat (n) begin
      @(negedge core_clk);
      if (sck_out === 1'b1) h++;
    end
    check(33'(h), 33'(e));
  endtask
  function logic [31:0] mode(input logic [3:0] op, input logic [1:0] s, input logic y, k, o);
    mode = {12'h0, o, k, 9'h0, y, 2'h0, s, op};
  endfunction
  task done(input string s); $display("test %s finished", s); endtask
  initial begin
    #400us;
    fail_count++;
    give_verdict();
  end
  initial begin
    void'($urandom(67));
    repeat (3) @(posedge core_clk);
    reset_n <= 1;
    rd(`MODE_REG_ADDR, 33'h0);
    rd(`BAUD_GEN_REG_ADDR, 33'h0);
    rd(`ISO_RATIO_REG_ADDR, {22'h0, `ISO_RATIO_RESET});
    rd(`ISO_CODE_REG_ADDR, {25'h0, `ISO_CODE_RESET});
    done("reset");
    for (int i = 0; i < 12; i++) begin
      wr(`ISO_CODE_REG_ADDR, {24'h0, fic[i], dic[i % 8]});
      rd(`ISO_DEC_REG_ADDR, {5'h0, 12'(fiv[i]), 10'h0, 6'(div[i % 8])});
    end
    wr(`ISO_DEC_REG_ADDR, 32'hffff_ffff);
    rd(`ISO_DEC_REG_ADDR, 33'h0_0800_0008);
    rd(8'h0c, {1'b1, 32'h0});
    done("map");
    cd = 2 + $urandom % 4;
    ov = $urandom % 2;
    wr(`MODE_REG_ADDR, mode(`OP_NORMAL, `SRC_MCK, 0, 0, ov[0]));
    wr(`BAUD_GEN_REG_ADDR, cd);
    meas(1, cd * (ov ? 8 : 16));
    wr(`MODE_REG_ADDR, 32'h0);
    wr(`BAUD_GEN_REG_ADDR, 32'h0004_0003);
    meas(2, 112);
    wr(`MODE_REG_ADDR, mode(`OP_NORMAL, `SRC_MCK_DIV, 0, 0, 1));
    wr(`BAUD_GEN_REG_ADDR, 32'h1);
    meas(1, 64);
    done("async");
    wr(`MODE_REG_ADDR, mode(`OP_ISO_T0, `SRC_MCK, 0, 1, 0));
    wr(`ISO_RATIO_REG_ADDR, 32'h5);
    wr(`BAUD_GEN_REG_ADDR, 32'h0004_0002);
    meas(1, 10);
    check(33'(sck_oe), 33'h1);
    wr(`MODE_REG_ADDR, mode(`OP_ISO_T1, `SRC_MCK, 0, 0, 0));
    meas(1, 10);
    check(33'(sck_oe), 33'h0);
    wr(`MODE_REG_ADDR, mode(`OP_NORMAL, `SRC_MCK, 1, 0, 0));
    wr(`BAUD_GEN_REG_ADDR, 32'h3);
    meas(1, 3);
    wr(`BAUD_GEN_REG_ADDR, 32'h4);
    meas(1, 4);
    duty(64, 32);
    wr(`MODE_REG_ADDR, mode(`OP_NORMAL, `SRC_MCK_DIV, 1, 0, 0));
    wr(`BAUD_GEN_REG_ADDR, 32'h2);
    meas(1, 16);
    duty(64, 32);
    wr(`BAUD_GEN_REG_ADDR, 32'h0);
    wr(`MODE_REG_ADDR, mode(`OP_NORMAL, `SRC_EXT, 1, 0, 0));
    run = 1;
    meas(2, 20);
    run = 0;
    wr(`MODE_REG_ADDR, 32'h0);
    meas(1, 0);
    done("modes");
    give_verdict();
  end
endmodule // test_usart_baud_rate_generator
